/* verilog/ufc_pkg.sv */
package ufc_pkg;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] BAUD_OFF   = 8'h04;
    localparam logic [7:0] TXDATA_OFF = 8'h08;
    localparam logic [7:0] RXDATA_OFF = 8'h0c;
    localparam logic [7:0] STAT_OFF   = 8'h10;
    localparam logic [7:0] IRQ_OFF    = 8'h14;
    localparam logic [7:0] MASK_OFF   = 8'h18;

    // Control fields.
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_PAR_BIT    = 1;
    localparam int CTRL_FLOW_BIT   = 2;
    localparam int CTRL_SLEEP_BIT  = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status fields.
    localparam int STAT_TXBUSY_BIT = 0;
    localparam int STAT_RXFULL_BIT = 1;
    localparam int STAT_CTS_BIT    = 2;
    localparam int STAT_RTS_BIT    = 3;

    // Sticky event bits.
    localparam int EV_TXDONE_BIT = 0;
    localparam int EV_RXDONE_BIT = 1;
    localparam int EV_PARERR_BIT = 2;
    localparam int EV_FRMERR_BIT = 3;
    localparam int EV_OVR_BIT    = 4;
    localparam int EV_W          = 5;

    // Timing.
    localparam int CLK_HZ       = 100_000_000;
    localparam int MAX_BAUD_BPS = 1_000_000;
    localparam int MIN_DIV      = CLK_HZ / MAX_BAUD_BPS;
    localparam int DIV_W        = 16;
    // Divider default gives 115200 baud (100e6/115200 rounded down).
    localparam logic [15:0] BAUD_RESET = 16'h0364;

    localparam int DATA_BITS = 8;

endpackage

/* verilog/ufc_baud.sv */
`timescale 1ns/1ps
`default_nettype none

// Divides clk by a programmable count into a one-cycle bit-rate pulse.
module ufc_baud #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] div,
    output logic                  tick
);

    logic [DIV_W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (!nrst || restart) begin
            cnt_reg <= '0;
        end else if (cnt_reg + 1'b1 >= div) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick = nrst && !restart && (cnt_reg + 1'b1 >= div);

endmodule
`default_nettype wire

/* verilog/ufc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for a pin level.
module ufc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q
);

    logic meta_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            q        <= RST_VAL;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule
`default_nettype wire

/* verilog/ufc_top.sv */
// Functional notes
// - Programmable baud generator, up to 1 Mbps.
// - Transmit on output, receive on input.
// - Flow control selectable on or off.
// - Request-to-send off when receiver cannot accept.
// - Eight data, optional even parity, one stop.
// - Reset format is eight, none, one.
// - Data bits least significant first.
`timescale 1ns/1ps
`default_nettype none

module ufc_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             txd,
    input  wire logic        rxd,
    output logic             rts_n,
    input  wire logic        cts_n,
    output logic             irq
);

    typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufc_tx_e;
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufc_rx_e;

    ////////////////////////////////////////////////////////////////////////
    logic [3:0]               ctrl_reg;
    logic [15:0]              baud_reg;
    logic [7:0]               txbuf_reg;
    logic                     txfull_reg;
    logic [7:0]               rxbuf_reg;
    logic                     rxfull_reg;
    logic [ufc_pkg::EV_W-1:0] ev_reg;
    logic [ufc_pkg::EV_W-1:0] mask_reg;
    logic [ufc_pkg::EV_W-1:0] ev_set;

    logic en;
    logic par_en;
    logic flow_en;
    logic sleep;
    assign en      = ctrl_reg[ufc_pkg::CTRL_EN_BIT];
    assign par_en  = ctrl_reg[ufc_pkg::CTRL_PAR_BIT];
    assign flow_en = ctrl_reg[ufc_pkg::CTRL_FLOW_BIT];
    assign sleep   = ctrl_reg[ufc_pkg::CTRL_SLEEP_BIT];

    logic wr;
    logic rd;
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign pready  = 1'b1;

    logic mapped;
    always_comb begin
        case (paddr)
            ufc_pkg::CTRL_OFF, ufc_pkg::BAUD_OFF, ufc_pkg::TXDATA_OFF,
            ufc_pkg::RXDATA_OFF, ufc_pkg::STAT_OFF, ufc_pkg::IRQ_OFF,
            ufc_pkg::MASK_OFF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic rxd_s;
    logic cts_n_s;

    ufc_sync #(.RST_VAL(1'b1)) u_rx_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (rxd),
        .q    (rxd_s)
    );

    ufc_sync #(.RST_VAL(1'b1)) u_cts_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (cts_n),
        .q    (cts_n_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg <= ufc_pkg::CTRL_RESET;
            baud_reg <= ufc_pkg::BAUD_RESET;
            mask_reg <= '0;
        end else if (wr) begin
            if (paddr == ufc_pkg::CTRL_OFF) begin
                ctrl_reg <= pwdata[3:0];
            end
            if (paddr == ufc_pkg::BAUD_OFF) begin
                // Divider clamps at the 1 Mbps ceiling.
                if (pwdata[15:0] < 16'(ufc_pkg::MIN_DIV)) begin
                    baud_reg <= 16'(ufc_pkg::MIN_DIV);
                end else begin
                    baud_reg <= pwdata[15:0];
                end
            end
            if (paddr == ufc_pkg::MASK_OFF) begin
                mask_reg <= pwdata[ufc_pkg::EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bit-rate ticks: transmit at bit rate, receive at sixteen times it.
    logic        tx_tick;
    logic        rx_tick;
    logic [15:0] rx_div;
    logic        rx_restart;
    assign rx_div = (baud_reg >> 4) == 16'h0000 ? 16'h0001 : baud_reg >> 4;

    ufc_baud #(.DIV_W(ufc_pkg::DIV_W)) u_tx_baud (
        .clk     (clk),
        .nrst    (nrst),
        .restart (!en),
        .div     (baud_reg),
        .tick    (tx_tick)
    );

    ufc_baud #(.DIV_W(ufc_pkg::DIV_W)) u_rx_baud (
        .clk     (clk),
        .nrst    (nrst),
        .restart (rx_restart),
        .div     (rx_div),
        .tick    (rx_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmitter.
    ufc_tx_e     tx_st_reg;
    logic [7:0]  tx_sh_reg;
    logic [2:0]  tx_cnt_reg;
    logic        tx_par_reg;
    logic        tx_load;
    logic        tx_ok;

    // Clear-to-send gates only the start of a new character.
    assign tx_ok   = !flow_en || !cts_n_s;
    assign tx_load = en && tx_tick && tx_st_reg == TX_IDLE
                     && txfull_reg && tx_ok;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_st_reg  <= TX_IDLE;
            tx_sh_reg  <= '0;
            tx_cnt_reg <= '0;
            tx_par_reg <= 1'b0;
            txd        <= 1'b1;
        end else if (!en) begin
            tx_st_reg <= TX_IDLE;
            txd       <= 1'b1;
        end else if (tx_tick) begin
            case (tx_st_reg)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_sh_reg  <= txbuf_reg;
                        tx_par_reg <= ^txbuf_reg;
                        txd        <= 1'b0;
                        tx_st_reg  <= TX_START;
                    end
                end
                TX_START, TX_DATA: begin
                    txd        <= tx_sh_reg[0];
                    tx_sh_reg  <= tx_sh_reg >> 1;
                    tx_cnt_reg <= tx_st_reg == TX_START ? 3'h0
                                  : tx_cnt_reg + 3'h1;
                    if (tx_st_reg == TX_DATA && tx_cnt_reg == 3'h6) begin
                        tx_st_reg <= par_en ? TX_PAR : TX_STOP;
                    end else begin
                        tx_st_reg <= TX_DATA;
                    end
                end
                TX_PAR: begin
                    txd       <= tx_par_reg;
                    tx_st_reg <= TX_STOP;
                end
                TX_STOP: begin
                    txd       <= 1'b1;
                    tx_st_reg <= TX_IDLE;
                end
                default: tx_st_reg <= TX_IDLE;
            endcase
        end
    end

    // One-byte holding register for transmit data.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            txbuf_reg  <= '0;
            txfull_reg <= 1'b0;
        end else if (wr && paddr == ufc_pkg::TXDATA_OFF && !txfull_reg) begin
            txbuf_reg  <= pwdata[7:0];
            txfull_reg <= 1'b1;
        end else if (tx_load) begin
            txfull_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver, sampling mid-bit on the sixteenth-rate tick.
    ufc_rx_e    rx_st_reg;
    logic [3:0] rx_os_reg;
    logic [2:0] rx_cnt_reg;
    logic [7:0] rx_sh_reg;
    logic       rx_par_reg;
    logic       rx_mid;
    logic       rx_done;
    logic       rx_perr;

    assign rx_restart = !en || rx_st_reg == RX_IDLE;
    assign rx_mid     = rx_tick && rx_os_reg == 4'hf;
    assign rx_done    = rx_mid && rx_st_reg == RX_STOP;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_st_reg  <= RX_IDLE;
            rx_os_reg  <= '0;
            rx_cnt_reg <= '0;
            rx_sh_reg  <= '0;
            rx_par_reg <= 1'b0;
        end else if (!en || sleep) begin
            rx_st_reg <= RX_IDLE;
        end else if (rx_st_reg == RX_IDLE) begin
            if (!rxd_s) begin
                rx_st_reg <= RX_START;
                rx_os_reg <= 4'h8;
            end
        end else if (rx_tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            if (rx_mid) begin
                case (rx_st_reg)
                    RX_START: begin
                        rx_cnt_reg <= '0;
                        rx_st_reg  <= rxd_s ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: begin
                        rx_sh_reg  <= {rxd_s, rx_sh_reg[7:1]};
                        rx_cnt_reg <= rx_cnt_reg + 3'h1;
                        if (rx_cnt_reg == 3'h7) begin
                            rx_st_reg <= par_en ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        rx_par_reg <= rxd_s;
                        rx_st_reg  <= RX_STOP;
                    end
                    RX_STOP: rx_st_reg <= RX_IDLE;
                    default: rx_st_reg <= RX_IDLE;
                endcase
            end
        end
    end

    assign rx_perr = par_en && (rx_par_reg != ^rx_sh_reg);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rxbuf_reg  <= '0;
            rxfull_reg <= 1'b0;
        end else if (rx_done && !rxfull_reg) begin
            rxbuf_reg  <= rx_sh_reg;
            rxfull_reg <= 1'b1;
        end else if (rd && paddr == ufc_pkg::RXDATA_OFF) begin
            rxfull_reg <= 1'b0;
        end
    end

    // Request-to-send is off whenever a new byte could not be kept.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rts_n <= 1'b1;
        end else begin
            rts_n <= flow_en && (rxfull_reg || sleep || !en);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events and interrupt; a set wins over a write-one clear.
    always_comb begin
        ev_set = '0;
        ev_set[ufc_pkg::EV_TXDONE_BIT] = tx_tick && tx_st_reg == TX_STOP;
        ev_set[ufc_pkg::EV_RXDONE_BIT] = rx_done && !rxfull_reg;
        ev_set[ufc_pkg::EV_PARERR_BIT] = rx_done && rx_perr;
        ev_set[ufc_pkg::EV_FRMERR_BIT] = rx_done && !rxd_s;
        ev_set[ufc_pkg::EV_OVR_BIT]    = rx_done && rxfull_reg;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ev_reg <= '0;
        end else if (wr && paddr == ufc_pkg::IRQ_OFF) begin
            ev_reg <= (ev_reg & ~pwdata[ufc_pkg::EV_W-1:0]) | ev_set;
        end else begin
            ev_reg <= ev_reg | ev_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(ev_reg & mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                ufc_pkg::CTRL_OFF:   prdata <= {28'h0, ctrl_reg};
                ufc_pkg::BAUD_OFF:   prdata <= {16'h0, baud_reg};
                ufc_pkg::RXDATA_OFF: prdata <= {24'h0, rxbuf_reg};
                ufc_pkg::STAT_OFF:   prdata <= {28'h0, rts_n, cts_n_s,
                                         rxfull_reg,
                                         txfull_reg || tx_st_reg != TX_IDLE};
                ufc_pkg::IRQ_OFF:    prdata <= {27'h0, ev_reg};
                ufc_pkg::MASK_OFF:   prdata <= {27'h0, mask_reg};
                default:             prdata <= '0;
            endcase
        end
    end

endmodule
`default_nettype wire

/* testbench/ufc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module ufc_checker (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd,
    input wire logic        rxd,
    input wire logic        rts_n,
    input wire logic        cts_n,
    input wire logic        irq
);
    logic [3:0]  ctrl_sh;
    logic [4:0]  mask_sh;
    logic [15:0] baud_sh;
    logic        txd_q;
    int          run_cnt;
    int          cts_cnt;
    int          lim;

    // Longest time one frame may still take at the programmed bit time.
    assign lim = 12 * ((baud_sh < 16'd100) ? 100 : int'(baud_sh)) + 8;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_sh <= 4'h0;
            mask_sh <= 5'h00;
            baud_sh <= ufc_pkg::BAUD_RESET;
        end else if (psel && penable && pwrite) begin
            if (paddr == ufc_pkg::CTRL_OFF) ctrl_sh <= pwdata[3:0];
            if (paddr == ufc_pkg::MASK_OFF) mask_sh <= pwdata[4:0];
            if (paddr == ufc_pkg::BAUD_OFF) baud_sh <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk) begin
        txd_q <= txd;
        if (!nrst) run_cnt <= 1000;
        else if (txd != txd_q) run_cnt <= 1;
        else if (run_cnt < 1000) run_cnt <= run_cnt + 1;
        if (!nrst || !ctrl_sh[2] || !cts_n) cts_cnt <= 0;
        else if (cts_cnt <= lim) cts_cnt <= cts_cnt + 1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_rx_off;
        (ctrl_sh[2] && (ctrl_sh[3] || !ctrl_sh[0])) [*2];
    endsequence

    sequence s_no_flow;
        !ctrl_sh[2] [*3];
    endsequence

    a_pready_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_unmapped_err: assert property (
        psel && penable && paddr > ufc_pkg::MASK_OFF |-> pslverr)
        else $error("no slave error on unmapped address");
    a_reset_idle_lines: assert property (
        disable iff (1'b0) !nrst |=> txd && rts_n && !irq)
        else $error("lines not idle under reset");
    a_bit_min_len: assert property (
        txd != txd_q |-> run_cnt >= ufc_pkg::MIN_DIV)
        else $error("serial bit shorter than the rate ceiling");
    a_rts_rx_off: assert property (s_rx_off |-> rts_n)
        else $error("request line active while receiver is off");
    a_rts_no_flow: assert property (s_no_flow |-> !rts_n)
        else $error("request line inactive without flow control");
    a_cts_hold_tx: assert property (cts_cnt > lim |-> txd)
        else $error("transmit while clear line inactive");
    a_irq_mask_zero: assert property (
        (mask_sh == 5'h00) [*2] |-> !irq)
        else $error("interrupt with all events masked");
endmodule

bind ufc_top ufc_checker u_chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
    .rts_n(rts_n), .cts_n(cts_n), .irq(irq)
);

`default_nettype wire

/* testbench/ufc_peer.sv */
`timescale 1ns/1ps
`default_nettype none

module ufc_peer #(
    parameter int BIT = 100
) (
    input  wire logic clk,
    input  wire logic txd,
    output var logic  rxd,
    output var logic  cts_n
);
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end

    task automatic allow(input logic v);
        @(posedge clk);
        cts_n <= !v;
    endtask

    task automatic take(input logic par, output logic [7:0] d,
                        output logic p, output logic s);
        int i;
        d = 8'hxx;
        p = 1'bx;
        s = 1'bx;
        for (i = 0; i < 20000 && txd === 1'b1; i++) @(posedge clk);
        if (txd !== 1'b0) return;
        repeat (BIT / 2) @(posedge clk);
        for (i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            d[i] = txd;
        end
        if (par) begin
            repeat (BIT) @(posedge clk);
            p = txd;
        end
        repeat (BIT) @(posedge clk);
        s = txd;
    endtask

    task automatic give(input logic [7:0] d, input logic par,
                        input logic bad_par, input logic stop);
        logic [10:0] f;
        int i;
        f = {stop, ^d ^ bad_par, d, 1'b0};
        for (i = 0; i < 11; i++) begin
            if (i != 9 || par) begin
                @(posedge clk);
                rxd <= f[i];
                repeat (BIT - 1) @(posedge clk);
            end
        end
        @(posedge clk);
        rxd <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic        txd, rxd, rts_n, cts_n, irq, er, pb, sb;
    logic [7:0]  paddr, bt;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] rows [4];
    int          n_mismatch;
    int          n_tests;

    ufc_top u_dut (
        .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd(txd), .rxd(rxd),
        .rts_n(rts_n), .cts_n(cts_n), .irq(irq)
    );
    ufc_peer u_peer (.clk(clk), .txd(txd), .rxd(rxd), .cts_n(cts_n));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic fail_out();
        n_mismatch++;
        close_out();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) fail_out();
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_bit(input logic [7:0] a, input int b);
        int i;
        for (i = 0; i < 64; i++) begin
            apb(1'b0, a, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        if (i == 64) fail_out();
    endtask

    initial begin
        int k;
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        n_mismatch = 0;
        n_tests = 0;
        rows = '{12'h155, 12'h3a3, 12'h301, 12'h180};
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b1, ufc_pkg::BAUD_OFF, 32'h5);
        apb(1'b0, ufc_pkg::BAUD_OFF, 32'h0);
        chk(rd, ufc_pkg::MIN_DIV);
        foreach (rows[k]) begin
            apb(1'b1, ufc_pkg::CTRL_OFF, {28'h0, rows[k][11:8]});
            apb(1'b1, ufc_pkg::TXDATA_OFF, {24'h0, rows[k][7:0]});
            u_peer.take(rows[k][9], bt, pb, sb);
            chk({23'h0, sb, bt}, {24'h1, rows[k][7:0]});
            chk({31'h0, rows[k][9] ? pb : 1'b0},
                {31'h0, rows[k][9] & ^rows[k][7:0]});
            u_peer.give(rows[k][7:0], rows[k][9], 1'b0, 1'b1);
            wait_bit(ufc_pkg::STAT_OFF, ufc_pkg::STAT_RXFULL_BIT);
            apb(1'b0, ufc_pkg::RXDATA_OFF, 32'h0);
            chk(rd, {24'h0, rows[k][7:0]});
            apb(1'b0, ufc_pkg::IRQ_OFF, 32'h0);
            chk(rd, 32'h03);
            apb(1'b1, ufc_pkg::IRQ_OFF, 32'h1f);
        end
        apb(1'b1, ufc_pkg::MASK_OFF, 32'h0c);
        apb(1'b1, ufc_pkg::CTRL_OFF, 32'h3);
        for (k = 0; k < 2; k++) begin
            u_peer.give(8'h3c, 1'b1, k == 0, k == 0);
            wait_bit(ufc_pkg::IRQ_OFF, ufc_pkg::EV_RXDONE_BIT);
            chk(rd, (k == 0) ? 32'h06 : 32'h0a);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, ufc_pkg::RXDATA_OFF, 32'h0);
            apb(1'b1, ufc_pkg::IRQ_OFF, 32'h1f);
            apb(1'b0, ufc_pkg::IRQ_OFF, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // The low stop bit is taken as a new start; let that frame drain.
        repeat (1200) @(posedge clk);
        apb(1'b0, ufc_pkg::RXDATA_OFF, 32'h0);
        apb(1'b1, ufc_pkg::IRQ_OFF, 32'h1f);
        apb(1'b1, ufc_pkg::CTRL_OFF, 32'h5);
        fork
            u_peer.take(1'b0, bt, pb, sb);
            begin
                apb(1'b1, ufc_pkg::TXDATA_OFF, 32'h96);
                repeat (300) @(posedge clk);
                u_peer.allow(1'b0);
            end
        join
        chk({23'h0, sb, bt}, 32'h196);
        apb(1'b1, ufc_pkg::TXDATA_OFF, 32'h69);
        repeat (1500) @(posedge clk);
        chk({31'h0, txd}, 32'h1);
        u_peer.allow(1'b1);
        u_peer.take(1'b0, bt, pb, sb);
        chk({23'h0, sb, bt}, 32'h169);
        u_peer.give(8'h5a, 1'b0, 1'b0, 1'b1);
        wait_bit(ufc_pkg::STAT_OFF, ufc_pkg::STAT_RXFULL_BIT);
        chk({31'h0, rts_n}, 32'h1);
        apb(1'b0, ufc_pkg::RXDATA_OFF, 32'h0);
        repeat (3) @(posedge clk);
        chk({23'h0, rts_n, rd[7:0]}, 32'h05a);
        apb(1'b1, ufc_pkg::CTRL_OFF, 32'hd);
        repeat (3) @(posedge clk);
        chk({31'h0, rts_n}, 32'h1);
        apb(1'b1, ufc_pkg::CTRL_OFF, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, rts_n}, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, ufc_pkg::CTRL_OFF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ufc_pkg::BAUD_OFF, 32'h0);
        chk(rd, {16'h0, ufc_pkg::BAUD_RESET});
        apb(1'b0, ufc_pkg::MASK_OFF, 32'h0);
        chk({rd[29:0], txd, irq}, 32'h2);
        close_out();
    end
endmodule

`default_nettype wire
